// >>> design/fpc_defs.vh
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// Register offsets
`define FPC_ADDR_ROOT_SEL   8'h04
`define FPC_ADDR_SYNTH_CTL  8'h05
`define FPC_ADDR_INT_FACTOR 8'h06
`define FPC_ADDR_FRAC_HIGH  8'h07
`define FPC_ADDR_FRAC_LOW   8'h08

// Field positions
`define FPC_CTL_ENABLE_BIT  7
`define FPC_CTL_PREDIV_MSB  6
`define FPC_CTL_PREDIV_LSB  4
`define FPC_CTL_MULT_MSB    3
`define FPC_CTL_MULT_LSB    0
`define FPC_INT_MSB         5
`define FPC_FRAC_HIGH_MSB   5
`define FPC_ROOT_SEL_MSB    1

// Reset values
`define FPC_RST_ROOT_SEL    2'h0
`define FPC_RST_SYNTH_CTL   8'h11
`define FPC_RST_INT_FACTOR  6'h04
`define FPC_RST_FRAC_HIGH   6'h00
`define FPC_RST_FRAC_LOW    8'h00

// Root clock sources
`define FPC_SRC_MASTER      2'h0
`define FPC_SRC_BIT_CLOCK   2'h1
`define FPC_SRC_GENERAL     2'h2
`define FPC_SRC_SYNTH       2'h3

// Timing
`define FPC_CLK_KHZ         125000
`define FPC_TIMER_OSC_KHZ   8200
`define FPC_TIMER_CYCLES    (`FPC_CLK_KHZ / `FPC_TIMER_OSC_KHZ)

`endif

// >>> design/fpc_pin_sync.v
`timescale 1ns/1ps
module fpc_pin_sync #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rstn,
  // Pin levels
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
      reg stage_one;
      reg stage_two;
      always @(posedge clk) begin
        if (!rstn) begin
          stage_one <= 1'b0;
          stage_two <= 1'b0;
        end else begin
          stage_one <= pin_in[i];
          stage_two <= stage_one;
        end
      end
      assign pin_sync[i] = stage_two;
    end
  endgenerate

endmodule

// >>> design/fpc_clock_config.v
// Notes on behaviour
// - Synthesizer enabled while control bit 7 is set, off while clear.
// - Output equals reference times multiplier times J.D over pre-divider.
// - Multiplier in control bits 3..0, values 1 to 16, reset 1.
// - Pre-divider in control bits 6..4, values 1 to 8, reset 1.
// - Integer factor in low six bits of its register, 1..63, reset 4.
// - Fraction is 14 bits, 0..9999, high six bits then low byte.
// - High fraction byte first; new fraction applies only after low write.
// - Synthesizer runs alone and can drive the general pin.
// - Two-bit field picks master, bit clock, general pin or synthesizer.
// - Nominal 8.2 MHz timer clock drives timers, debounce, interrupts.
// - Select value three picks synthesizer, fed from the master clock.
// - Writing 0x91 enables with pre-divider and multiplier of one.
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_clock_config #(
  parameter TIMER_CYCLES = `FPC_TIMER_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Clock pins
  input  wire        master_clk_pin,
  input  wire        bit_clk_pin,
  input  wire        general_pin_one_in,
  input  wire        synth_clk_in,
  input  wire        route_synth_to_pin,
  // Synthesizer setting
  output reg         synth_enable,
  output reg  [3:0]  synth_pre_divider,
  output reg  [4:0]  synth_multiplier,
  output reg  [5:0]  synth_integer_factor,
  output reg  [13:0] synth_fraction_factor,
  output reg         synth_ref_clk,
  // Clock outputs
  output reg         root_clk,
  output reg         general_pin_one_out,
  output reg         general_pin_one_oe,
  output reg         timer_tick
);

  reg  [1:0]  root_sel;
  reg  [7:0]  synth_ctl;
  reg  [5:0]  int_factor;
  reg  [5:0]  frac_high_stage;
  reg  [7:0]  frac_low;
  reg  [15:0] timer_count;
  reg  [7:0]  next_rdata;
  reg         next_root;
  wire [3:0]  pins;
  wire [4:0]  prediv_value;
  wire [4:0]  mult_value;
  wire        wr_root;
  wire        wr_ctl;
  wire        wr_int;
  wire        wr_frac_high;
  wire        wr_frac_low;
  wire        timer_wrap;

  // Pin synchronisers
  fpc_pin_sync #(
    .WIDTH (4)
  ) fpc_pin_sync_i (
    .clk      (clk),
    .rstn     (rstn),
    .pin_in   ({synth_clk_in, general_pin_one_in, bit_clk_pin,
                master_clk_pin}),
    .pin_sync (pins)
  );

  // Zero field code stands for the largest factor
  function [4:0] fpc_factor;
    input [3:0] code;
    input [4:0] top;
    begin
      fpc_factor = (code == 4'h0) ? top : {1'b0, code};
    end
  endfunction

  function fpc_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      fpc_hit = (addr == target);
    end
  endfunction

  // Write decodes
  assign wr_root      = reg_wr & fpc_hit(reg_addr, `FPC_ADDR_ROOT_SEL);
  assign wr_ctl       = reg_wr & fpc_hit(reg_addr, `FPC_ADDR_SYNTH_CTL);
  assign wr_int       = reg_wr & fpc_hit(reg_addr, `FPC_ADDR_INT_FACTOR);
  assign wr_frac_high = reg_wr & fpc_hit(reg_addr, `FPC_ADDR_FRAC_HIGH);
  assign wr_frac_low  = reg_wr & fpc_hit(reg_addr, `FPC_ADDR_FRAC_LOW);

  // Field codes to factors
  assign prediv_value = fpc_factor(
    {1'b0, synth_ctl[`FPC_CTL_PREDIV_MSB:`FPC_CTL_PREDIV_LSB]}, 5'h08);
  assign mult_value = fpc_factor(
    synth_ctl[`FPC_CTL_MULT_MSB:`FPC_CTL_MULT_LSB], 5'h10);

  // Register writes
  always @(posedge clk) begin
    if (!rstn) begin
      root_sel        <= `FPC_RST_ROOT_SEL;
      synth_ctl       <= `FPC_RST_SYNTH_CTL;
      int_factor      <= `FPC_RST_INT_FACTOR;
      frac_high_stage <= `FPC_RST_FRAC_HIGH;
      frac_low        <= `FPC_RST_FRAC_LOW;
      synth_fraction_factor <= 14'h0000;
    end else begin
      if (wr_root) begin
        root_sel <= reg_wdata[`FPC_ROOT_SEL_MSB:0];
      end
      if (wr_ctl) begin
        synth_ctl <= reg_wdata;
      end
      if (wr_int) begin
        int_factor <= reg_wdata[`FPC_INT_MSB:0];
      end
      if (wr_frac_high) begin
        frac_high_stage <= reg_wdata[`FPC_FRAC_HIGH_MSB:0];
      end
      if (wr_frac_low) begin
        frac_low <= reg_wdata;
        synth_fraction_factor <= {frac_high_stage, reg_wdata};
      end
    end
  end

  // Active synthesizer setting
  always @(posedge clk) begin
    if (!rstn) begin
      synth_enable         <= 1'b0;
      synth_pre_divider    <= 4'h1;
      synth_multiplier     <= 5'h01;
      synth_integer_factor <= `FPC_RST_INT_FACTOR;
      synth_ref_clk        <= 1'b0;
    end else begin
      synth_enable <= synth_ctl[`FPC_CTL_ENABLE_BIT];
      synth_pre_divider <= prediv_value[3:0];
      synth_multiplier <= mult_value;
      synth_integer_factor <= int_factor;
      synth_ref_clk <= pins[0];
    end
  end

  // Root clock selection
  always @* begin
    case (root_sel)
      `FPC_SRC_MASTER:    next_root = pins[0];
      `FPC_SRC_BIT_CLOCK: next_root = pins[1];
      `FPC_SRC_GENERAL:   next_root = pins[2];
      `FPC_SRC_SYNTH:     next_root = pins[3] & synth_enable;
      default:            next_root = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      root_clk            <= 1'b0;
      general_pin_one_out <= 1'b0;
      general_pin_one_oe  <= 1'b0;
    end else begin
      root_clk            <= next_root;
      general_pin_one_out <= pins[3] & synth_enable;
      general_pin_one_oe  <= route_synth_to_pin;
    end
  end

  // Timer reference tick
  assign timer_wrap = (timer_count >= TIMER_CYCLES[15:0] - 16'h0001);

  always @(posedge clk) begin
    if (!rstn) begin
      timer_count <= 16'h0000;
    end else if (timer_wrap) begin
      timer_count <= 16'h0000;
    end else begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= timer_wrap;
    end
  end

  // Read data
  always @* begin
    case (reg_addr)
      `FPC_ADDR_ROOT_SEL:   next_rdata = {6'h00, root_sel};
      `FPC_ADDR_SYNTH_CTL:  next_rdata = synth_ctl;
      `FPC_ADDR_INT_FACTOR: next_rdata = {2'h0, int_factor};
      `FPC_ADDR_FRAC_HIGH:  next_rdata = {2'h0, frac_high_stage};
      `FPC_ADDR_FRAC_LOW:   next_rdata = frac_low;
      default:              next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// >>> verif/fpc_clock_config_asserts.sv
`timescale 1ns/1ps
module fpc_asserts #(
  parameter int TIMER_CYCLES = 15
) (
  // Clock and reset
  input        clk,
  input        rstn,
  // Register port
  input [7:0]  reg_addr,
  input        reg_wr,
  input [7:0]  reg_wdata,
  input        reg_rd,
  input [7:0]  reg_rdata,
  // Outputs
  input        synth_enable,
  input [3:0]  synth_pre_divider,
  input [4:0]  synth_multiplier,
  input [5:0]  synth_integer_factor,
  input [13:0] synth_fraction_factor,
  input        timer_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_en;
    reg_wr && reg_addr == 8'h05 |-> ##2
      synth_enable == $past(reg_wdata[7], 2);
  endproperty
  a_en: assert property (p_en) else $error("bad enable");
  property p_mul;
    reg_wr && reg_addr == 8'h05 |-> ##2 synth_multiplier ==
      {$past(reg_wdata[3:0], 2) == 0, $past(reg_wdata[3:0], 2)};
  endproperty
  a_mul: assert property (p_mul) else $error("bad mult");
  property p_pre;
    reg_wr && reg_addr == 8'h05 |-> ##2 synth_pre_divider ==
      {$past(reg_wdata[6:4], 2) == 0, $past(reg_wdata[6:4], 2)};
  endproperty
  a_pre: assert property (p_pre) else $error("bad prediv");
  property p_int;
    reg_wr && reg_addr == 8'h06 |-> ##2
      synth_integer_factor == $past(reg_wdata[5:0], 2);
  endproperty
  a_int: assert property (p_int) else $error("bad integer");
  property p_lo;
    reg_wr && reg_addr == 8'h08 |=>
      synth_fraction_factor[7:0] == $past(reg_wdata);
  endproperty
  a_lo: assert property (p_lo) else $error("bad fraction");
  property p_hi;
    reg_wr && reg_addr == 8'h07 |=> $stable(synth_fraction_factor);
  endproperty
  a_hi: assert property (p_hi) else $error("early fraction");
  property p_rd;
    reg_rd && reg_addr > 8'h08 |=> reg_rdata == 8'h00;
  endproperty
  a_rd: assert property (p_rd) else $error("bad unmapped read");
  property p_tp;
    timer_tick |-> ##TIMER_CYCLES timer_tick;
  endproperty
  a_tp: assert property (p_tp) else $error("bad tick period");
  property p_tw;
    timer_tick |=> !timer_tick;
  endproperty
  a_tw: assert property (p_tw) else $error("long tick");
endmodule

bind fpc_clock_config fpc_asserts #(.TIMER_CYCLES(TIMER_CYCLES))
  fpc_asserts_i (.*);

// >>> verif/fpc_clock_config_tb.sv
`timescale 1ns/1ps
`include "fpc_defs.vh"
module fpc_clock_config_tb;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [7:0]  ad = 8'h00;
  reg         wr_s = 1'b0;
  reg  [7:0]  wd = 8'h00;
  reg         rd_s = 1'b0;
  reg  [3:0]  pins = 4'h0;
  reg         route = 1'b0;
  wire [7:0]  rdat;
  wire        en;
  wire        root;
  wire        gpo;
  wire        gpe;
  wire [3:0]  pre;
  wire [4:0]  mul;
  wire [5:0]  jf;
  wire [13:0] frac;
  wire        sref;
  wire        tick;
  int         bad_count = 0;
  int         checks = 0;
  int         cyc = 0;
  int         i;
  int         n;
  fpc_clock_config fpc_clock_config_i (
    .clk(clk), .rstn(rstn), .reg_addr(ad), .reg_wr(wr_s),
    .reg_wdata(wd), .reg_rd(rd_s), .reg_rdata(rdat),
    .master_clk_pin(pins[0]), .bit_clk_pin(pins[1]),
    .general_pin_one_in(pins[2]), .synth_clk_in(pins[3]),
    .route_synth_to_pin(route), .synth_enable(en),
    .synth_pre_divider(pre), .synth_multiplier(mul),
    .synth_integer_factor(jf), .synth_fraction_factor(frac),
    .synth_ref_clk(sref), .root_clk(root), .general_pin_one_out(gpo),
    .general_pin_one_oe(gpe), .timer_tick(tick));
  always #4 clk = ~clk;
  task conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude;
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    ad = a;
    wd = d;
    wr_s = 1'b1;
    step(1);
    wr_s = 1'b0;
    step(1);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    ad = a;
    rd_s = 1'b1;
    step(1);
    rd_s = 1'b0;
    chk("rdata", e, rdat);
    step(1);
  endtask
  initial begin
    step(10);
    rstn = 1'b1;
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h11);
    rd(8'h06, 8'h04);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h40, 8'h00);
    chk("setting", 30'h2110000, {en, pre, mul, jf, frac});
    $display("reset test done");
    for (i = 0; i < 16; i++) begin
      wr(8'h05, {i[0], i[2:0], i[3:0]});
      rd(8'h05, {i[0], i[2:0], i[3:0]});
      chk("ctl", {i[0], i[2:0] == 0, i[2:0], i[3:0] == 0, i[3:0]},
        {en, pre, mul});
    end
    wr(8'h05, 8'h91);
    step(20);
    chk("ctl", 10'h221, {en, pre, mul});
    wr(8'h06, 8'hff);
    rd(8'h06, 8'h3f);
    chk("int", 6'h3f, jf);
    wr(8'h07, 8'h27);
    chk("frac", 14'h0000, frac);
    rd(8'h07, 8'h27);
    wr(8'h08, 8'h0f);
    chk("frac", 14'h270f, frac);
    wr(8'h07, 8'h27);
    chk("frac", 14'h270f, frac);
    wr(8'h08, 8'h00);
    chk("frac", 14'h2700, frac);
    $display("fraction test done");
    route = 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(8'h04, i[7:0]);
      pins = ~(4'h1 << i);
      step(4);
      chk("root", 1'b0, root);
      chk("ref", pins[0], sref);
      pins = 4'h1 << i;
      step(4);
      chk("root", 1'b1, root);
      chk("ref", pins[0], sref);
    end
    chk("pin", 2'b11, {gpe, gpo});
    pins = 4'h9;
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h11);
    step(4);
    chk("root", 3'b101, {gpe, gpo, root});
    $display("root test done");
    while (tick !== 1'b1) step(1);
    step(1);
    chk("tick", 1'b0, tick);
    n = 1;
    while (tick !== 1'b1) begin
      step(1);
      n++;
    end
    chk("tick", `FPC_TIMER_CYCLES, n);
    $display("timer test done");
    conclude;
  end
endmodule
